// [core/ecsr_defines.svh]
`ifndef ECSR_DEFINES_SVH
`define ECSR_DEFINES_SVH

// Byte addresses on the AHB-Lite bus
`define ECSR_OFF_CTRL1 12'h000
`define ECSR_OFF_TXSTAT 12'h004
`define ECSR_OFF_STAT 12'h008
`define ECSR_OFF_CHKSUM 12'h00C
`define ECSR_OFF_MACCTL2 12'h010
`define ECSR_OFF_EIR 12'h014
`define ECSR_OFF_EIE 12'h018

// Control register one fields
`define ECSR_B_CIPHER_START 11
`define ECSR_B_CIPHER_OP_HI 10
`define ECSR_B_CIPHER_OP_LO 9
`define ECSR_B_PKT_DEC 8
`define ECSR_B_FC_HI 7
`define ECSR_B_FC_LO 6
`define ECSR_B_DMA_START 5
`define ECSR_B_DMA_COPY 4
`define ECSR_B_DMA_SEED 3
`define ECSR_B_DMA_NOCS 2
`define ECSR_B_TX_REQ 1
`define ECSR_B_RX_EN 0

// Transmit status fields
`define ECSR_B_LATE_COL 10
`define ECSR_B_MAX_COL 9
`define ECSR_B_EXC_DEFER 8
`define ECSR_B_DEFER 7
`define ECSR_B_CRC_BAD 4

// Global status fields, and the global enable bit of the interrupt enable register
`define ECSR_B_INT 15
`define ECSR_B_FC_IDLE 14
`define ECSR_B_RX_ACTIVE 13
`define ECSR_B_CLK_RDY 12
`define ECSR_B_PHY_DPX 10
`define ECSR_B_PHY_LNK 8
`define ECSR_B_GIE 15

// Reset values
`define ECSR_RST_CTRL1 16'h0000
`define ECSR_RST_TXSTAT 16'h0000
`define ECSR_RST_CHKSUM 16'h0000

// Excessive defer limit in bit times
`define ECSR_EXC_DEFER_BITS 24288
`define ECSR_LATE_COL_EXTRA 8

`endif

// [core/ecsr_pkg.sv]
package ecsr_pkg;
    typedef enum logic [1:0] {
        ECSR_CIPH_ENC_ECB = 2'h0,
        ECSR_CIPH_ENC_CBC = 2'h1,
        ECSR_CIPH_DEC = 2'h2,
        ECSR_CIPH_RSVD = 2'h3
    } ecsr_cipher_op_t;

    typedef enum logic [1:0] {
        ECSR_FC_IDLE = 2'h0,
        ECSR_FC_SINGLE = 2'h1,
        ECSR_FC_PERIODIC = 2'h2,
        ECSR_FC_END = 2'h3
    } ecsr_fc_op_t;

    typedef enum logic [3:0] {
        ECSR_FS_IDLE = 4'h1,
        ECSR_FS_PAUSE = 4'h2,
        ECSR_FS_PERIOD = 4'h4,
        ECSR_FS_BACKP = 4'h8
    } ecsr_fc_state_t;
endpackage

// [core/ecsr_regs.sv]
`timescale 1ns/10ps
`include "ecsr_defines.svh"

module ecsr_regs #(
    parameter int PAUSE_PERIOD = 4096
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic cipher_go,
    output ecsr_pkg::ecsr_cipher_op_t cipher_operation_select,
    input wire logic cipher_done,
    output logic dma_go,
    output logic dma_copy_control,
    output logic dma_seed_en,
    output logic [15:0] dma_seed,
    output logic dma_no_checksum,
    input wire logic dma_done,
    input wire logic [15:0] dma_checksum_in,
    output logic tx_go,
    input wire logic tx_done,
    input wire logic tx_late_col,
    input wire logic tx_max_col,
    input wire logic tx_exc_defer,
    input wire logic tx_defer,
    input wire logic tx_crc_bad,
    input wire logic [3:0] tx_col_count,
    output logic receive_enable_bit,
    input wire logic rx_pkt_stored,
    input wire logic receive_active_in,
    input wire logic clocks_ready_in,
    input wire logic phy_duplex_in,
    input wire logic phy_link_in,
    output logic pause_send,
    output logic pause_zero,
    input wire logic pause_done,
    output logic backpressure,
    output logic int_n
);
    import ecsr_pkg::*;

    // Register state
    logic [15:0] ctrl_ff;
    logic [15:0] txstat_ff;
    logic [15:0] chksum_ff;
    logic [15:0] eir_ff;
    logic [15:0] eie_ff;
    logic full_duplex_select_ff;
    logic [7:0] received_packet_count_ff;
    logic [1:0] rxa_s_ff;
    logic [1:0] clk_s_ff;
    logic [1:0] dpx_s_ff;
    logic [1:0] lnk_s_ff;
    ecsr_fc_state_t fc_state_ff;
    logic [15:0] period_cnt_ff;
    logic [11:0] addr_ff;
    logic wr_ff;
    logic rd_ff;
    logic go_cipher_ff;
    logic go_dma_ff;
    logic go_tx_ff;
    logic [15:0] rdval;
    logic int_pend;
    logic dec_req;
    logic flow_control_idle;

    // AHB-Lite address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 12'h000;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            if (hready) begin
                addr_ff <= haddr;
                wr_ff <= hsel && htrans[1] && hwrite;
                rd_ff <= hsel && htrans[1] && !hwrite;
            end
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Status synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxa_s_ff <= 2'h0;
            clk_s_ff <= 2'h0;
            dpx_s_ff <= 2'h0;
            lnk_s_ff <= 2'h0;
        end else begin
            rxa_s_ff <= {rxa_s_ff[0], receive_active_in};
            clk_s_ff <= {clk_s_ff[0], clocks_ready_in};
            dpx_s_ff <= {dpx_s_ff[0], phy_duplex_in};
            lnk_s_ff <= {lnk_s_ff[0], phy_link_in};
        end
    end

    // Control register write in its data phase
    wire wr_ctrl = wr_ff && (addr_ff == `ECSR_OFF_CTRL1);
    // Packet decrement strobe, never stored
    assign dec_req = wr_ctrl && hwdata[`ECSR_B_PKT_DEC];

    // Control register one with hardware clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `ECSR_RST_CTRL1;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= hwdata[15:0];
                ctrl_ff[`ECSR_B_PKT_DEC] <= 1'b0;
                if (!flow_control_idle) begin
                    ctrl_ff[`ECSR_B_FC_HI:`ECSR_B_FC_LO] <= ctrl_ff[`ECSR_B_FC_HI:`ECSR_B_FC_LO];
                end
                // A busy start bit keeps its value
                if (ctrl_ff[`ECSR_B_CIPHER_START] && !cipher_done) begin
                    ctrl_ff[`ECSR_B_CIPHER_START] <= 1'b1;
                end
                if (ctrl_ff[`ECSR_B_DMA_START] && !dma_done) begin
                    ctrl_ff[`ECSR_B_DMA_START] <= 1'b1;
                end
                if (ctrl_ff[`ECSR_B_TX_REQ] && !tx_done) begin
                    ctrl_ff[`ECSR_B_TX_REQ] <= 1'b1;
                end
            end
            // Completions come last so that a write never hides them
            if (cipher_done) begin
                ctrl_ff[`ECSR_B_CIPHER_START] <= 1'b0;
            end
            if (dma_done) begin
                ctrl_ff[`ECSR_B_DMA_START] <= 1'b0;
            end
            if (tx_done) begin
                ctrl_ff[`ECSR_B_TX_REQ] <= 1'b0;
            end
            // Codes 11 and 01 both have the low bit set and clear themselves on pause_done in full duplex
            if (pause_done && full_duplex_select_ff && ctrl_ff[`ECSR_B_FC_LO]) begin
                ctrl_ff[`ECSR_B_FC_HI:`ECSR_B_FC_LO] <= 2'h0;
            end
        end
    end

    // Start pulses on rising start bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            go_cipher_ff <= 1'b0;
            go_dma_ff <= 1'b0;
            go_tx_ff <= 1'b0;
        end else begin
            go_cipher_ff <= wr_ctrl && hwdata[`ECSR_B_CIPHER_START] && !ctrl_ff[`ECSR_B_CIPHER_START];
            go_dma_ff <= wr_ctrl && hwdata[`ECSR_B_DMA_START] && !ctrl_ff[`ECSR_B_DMA_START];
            go_tx_ff <= wr_ctrl && hwdata[`ECSR_B_TX_REQ] && !ctrl_ff[`ECSR_B_TX_REQ];
        end
    end

    // Engine controls from the control register
    assign cipher_go = go_cipher_ff;
    assign cipher_operation_select =
        ecsr_cipher_op_t'(ctrl_ff[`ECSR_B_CIPHER_OP_HI:`ECSR_B_CIPHER_OP_LO]);
    assign dma_go = go_dma_ff;
    assign dma_copy_control = ctrl_ff[`ECSR_B_DMA_COPY];
    assign dma_seed_en = ctrl_ff[`ECSR_B_DMA_SEED];
    assign dma_seed = ctrl_ff[`ECSR_B_DMA_SEED] ? ~chksum_ff : 16'h0000;
    assign dma_no_checksum = ctrl_ff[`ECSR_B_DMA_NOCS];
    assign tx_go = go_tx_ff;
    assign receive_enable_bit = ctrl_ff[`ECSR_B_RX_EN];

    // Checksum register, mac control two, interrupt registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chksum_ff <= `ECSR_RST_CHKSUM;
            full_duplex_select_ff <= 1'b0;
            eir_ff <= 16'h0000;
            eie_ff <= 16'h0000;
        end else begin
            if (dma_done && !ctrl_ff[`ECSR_B_DMA_NOCS]) begin
                chksum_ff <= dma_checksum_in;
            end else if (wr_ff && addr_ff == `ECSR_OFF_CHKSUM) begin
                chksum_ff <= hwdata[15:0];
            end
            if (wr_ff && addr_ff == `ECSR_OFF_MACCTL2 && flow_control_idle) begin
                full_duplex_select_ff <= hwdata[0];
            end
            if (wr_ff && addr_ff == `ECSR_OFF_EIR) begin
                eir_ff <= hwdata[15:0];
            end
            if (wr_ff && addr_ff == `ECSR_OFF_EIE) begin
                eie_ff <= hwdata[15:0];
            end
        end
    end

    // Transmit status captured at end of each frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txstat_ff <= `ECSR_RST_TXSTAT;
        end else begin
            if (tx_done) begin
                txstat_ff <= 16'h0000;
                txstat_ff[`ECSR_B_LATE_COL] <= tx_late_col && !full_duplex_select_ff;
                txstat_ff[`ECSR_B_MAX_COL] <= tx_max_col && !full_duplex_select_ff;
                txstat_ff[`ECSR_B_EXC_DEFER] <= tx_exc_defer && !full_duplex_select_ff;
                txstat_ff[`ECSR_B_DEFER] <= tx_defer && !tx_exc_defer &&
                    !full_duplex_select_ff;
                txstat_ff[`ECSR_B_CRC_BAD] <= tx_crc_bad;
                txstat_ff[3:0] <= full_duplex_select_ff ? 4'h0 : tx_col_count;
            end
        end
    end

    // Packet counter, increment and decrement together cancel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            received_packet_count_ff <= 8'h00;
        end else begin
            if (rx_pkt_stored && !dec_req) begin
                received_packet_count_ff <= received_packet_count_ff + 8'h01;
            end else if (dec_req && !rx_pkt_stored) begin
                received_packet_count_ff <= received_packet_count_ff - 8'h01;
            end
        end
    end

    // Flow control state machine
    wire [1:0] fc_op = ctrl_ff[`ECSR_B_FC_HI:`ECSR_B_FC_LO];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fc_state_ff <= ECSR_FS_IDLE;
            period_cnt_ff <= 16'h0000;
        end else begin
            case (fc_state_ff)
                ECSR_FS_IDLE: begin
                    period_cnt_ff <= 16'h0000;
                    if (!full_duplex_select_ff && fc_op != 2'h0) begin
                        fc_state_ff <= ECSR_FS_BACKP;
                    end else if (full_duplex_select_ff && fc_op != 2'h0) begin
                        fc_state_ff <= ECSR_FS_PAUSE;
                    end
                end
                ECSR_FS_PAUSE: begin
                    if (pause_done) begin
                        fc_state_ff <= (fc_op == ECSR_FC_PERIODIC) ? ECSR_FS_PERIOD : ECSR_FS_IDLE;
                    end
                end
                ECSR_FS_PERIOD: begin
                    period_cnt_ff <= period_cnt_ff + 16'h0001;
                    if (fc_op != ECSR_FC_PERIODIC) begin
                        fc_state_ff <= (fc_op == 2'h0) ? ECSR_FS_IDLE : ECSR_FS_PAUSE;
                    end else if (period_cnt_ff == 16'(PAUSE_PERIOD - 1)) begin
                        period_cnt_ff <= 16'h0000;
                        fc_state_ff <= ECSR_FS_PAUSE;
                    end
                end
                ECSR_FS_BACKP: begin
                    if (fc_op == 2'h0) begin
                        fc_state_ff <= ECSR_FS_IDLE;
                    end
                end
                default: begin
                    fc_state_ff <= ECSR_FS_IDLE;
                end
            endcase
        end
    end

    // Busy while a nonzero flow control code waits in idle or a pause frame is going out
    always_comb begin
        case (fc_state_ff)
            ECSR_FS_IDLE: flow_control_idle = (fc_op == 2'h0);
            ECSR_FS_PAUSE: flow_control_idle = 1'b0;
            ECSR_FS_PERIOD: flow_control_idle = 1'b1;
            ECSR_FS_BACKP: flow_control_idle = 1'b1;
            default: flow_control_idle = 1'b0;
        endcase
    end

    // Flow control outputs
    assign pause_send = (fc_state_ff == ECSR_FS_PAUSE);
    assign pause_zero = (fc_op == ECSR_FC_END);
    assign backpressure = (fc_state_ff == ECSR_FS_BACKP);

    // Interrupt pending and pin
    assign int_pend = |(eir_ff & eie_ff & 16'h7FFF);
    assign int_n = !(int_pend && eie_ff[`ECSR_B_GIE]);

    // Read mux
    always_comb begin
        rdval = 16'h0000;
        case (addr_ff)
            `ECSR_OFF_CTRL1: rdval = ctrl_ff;
            `ECSR_OFF_TXSTAT: rdval = txstat_ff;
            `ECSR_OFF_STAT: begin
                rdval[`ECSR_B_INT] = int_pend;
                rdval[`ECSR_B_FC_IDLE] = flow_control_idle;
                rdval[`ECSR_B_RX_ACTIVE] = rxa_s_ff[1];
                rdval[`ECSR_B_CLK_RDY] = clk_s_ff[1];
                rdval[`ECSR_B_PHY_DPX] = dpx_s_ff[1];
                rdval[`ECSR_B_PHY_LNK] = lnk_s_ff[1];
                rdval[7:0] = received_packet_count_ff;
            end
            `ECSR_OFF_CHKSUM: rdval = chksum_ff;
            `ECSR_OFF_MACCTL2: rdval = {15'h0000, full_duplex_select_ff};
            `ECSR_OFF_EIR: rdval = eir_ff;
            `ECSR_OFF_EIE: rdval = eie_ff;
            default: rdval = 16'h0000;
        endcase
    end

    // Read data shows only in the data phase of a read
    assign hrdata = rd_ff ? {16'h0000, rdval} : 32'h00000000;
endmodule // ecsr_regs

// [tb/ecsr_regs_chk.sv]
`timescale 1ns/10ps
module ecsr_regs_chk #(
    parameter int PAUSE_PERIOD = 4096
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cipher_go,
    input wire logic cipher_done,
    input wire logic dma_go,
    input wire logic dma_done,
    input wire logic tx_go,
    input wire logic tx_done,
    input wire logic dma_seed_en,
    input wire logic [15:0] dma_seed,
    input wire logic pause_send,
    input wire logic backpressure
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Data phase of a control write, and engine busy spans
    logic wr_ff;
    logic cb_ff;
    logic db_ff;
    logic tb_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'h0;
            cb_ff <= 1'h0;
            db_ff <= 1'h0;
            tb_ff <= 1'h0;
        end else begin
            wr_ff <= hsel && htrans[1] && hready && hwrite && (haddr == 12'h000);
            cb_ff <= cipher_go || (cb_ff && !cipher_done);
            db_ff <= dma_go || (db_ff && !dma_done);
            tb_ff <= tx_go || (tb_ff && !tx_done);
        end
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_cipher_launch: assert property (
        wr_ff && hwdata[11] && !cb_ff |=> cipher_go) else $error("cipher not launched");
    chk_cipher_busy: assert property (cb_ff |-> !cipher_go)
        else $error("cipher relaunched while busy");
    chk_dma_launch: assert property (
        wr_ff && hwdata[5] && !db_ff |=> dma_go) else $error("dma not launched");
    chk_dma_pulse: assert property (dma_go |=> !dma_go)
        else $error("dma launch longer than a cycle");
    chk_tx_launch: assert property (
        wr_ff && hwdata[1] && !tb_ff |=> tx_go) else $error("transmit not launched");
    chk_seed_zero: assert property (!dma_seed_en |-> dma_seed == 16'h0000)
        else $error("seed not zero");
    chk_bp_excl: assert property ($rose(backpressure) |-> !pause_send)
        else $error("backpressure with pause frame");
endmodule // ecsr_regs_chk

// [tb/ecsr_engine_model.sv]
`timescale 1ns/10ps
module ecsr_engine_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] lat,
    input wire logic cipher_go,
    input wire logic dma_go,
    input wire logic tx_go,
    input wire logic pause_send,
    output logic cipher_done,
    output logic dma_done,
    output logic tx_done,
    output logic pause_done
);
    // Each engine answers lat+1 cycles after its launch pulse, the pause engine lat+1 cycles after pause_send rises
    logic [7:0] cc, dc, tc, pc;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc <= 8'h00;
            dc <= 8'h00;
            tc <= 8'h00;
            pc <= 8'h00;
            cipher_done <= 1'h0;
            dma_done <= 1'h0;
            tx_done <= 1'h0;
            pause_done <= 1'h0;
        end else begin
            cc <= cipher_go ? lat : (cc != 8'h00 ? cc - 8'h01 : 8'h00);
            dc <= dma_go ? lat : (dc != 8'h00 ? dc - 8'h01 : 8'h00);
            tc <= tx_go ? lat : (tc != 8'h00 ? tc - 8'h01 : 8'h00);
            pc <= (pause_send && !pause_done) ? pc + 8'h01 : 8'h00;
            cipher_done <= (cc == 8'h01);
            dma_done <= (dc == 8'h01);
            tx_done <= (tc == 8'h01);
            pause_done <= (pc == lat);
        end
    end
endmodule // ecsr_engine_model

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import ecsr_pkg::*;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, cipher_go, dma_go, dma_copy_control, dma_seed_en, dma_no_checksum;
    logic tx_go, receive_enable_bit, pause_send, pause_zero, backpressure, int_n;
    logic cipher_done, dma_done, tx_done, pause_done;
    logic tx_late_col = 1'h0, tx_max_col = 1'h0, tx_exc_defer = 1'h0, tx_defer = 1'h0;
    logic tx_crc_bad = 1'h0, rx_pkt_stored = 1'h0, receive_active_in = 1'h0;
    logic clocks_ready_in = 1'h0, phy_duplex_in = 1'h0, phy_link_in = 1'h0;
    logic [3:0] tx_col_count = 4'h0;
    logic [15:0] dma_seed, dma_checksum_in = 16'h0000;
    logic [7:0] lat = 8'h14;
    ecsr_cipher_op_t cipher_operation_select;
    int err_count = 0;
    int check_count = 0;
    always #10 hclk = ~hclk;
    ecsr_regs #(.PAUSE_PERIOD(8)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cipher_go,
        .cipher_operation_select, .cipher_done, .dma_go, .dma_copy_control, .dma_seed_en,
        .dma_seed, .dma_no_checksum, .dma_done, .dma_checksum_in, .tx_go, .tx_done,
        .tx_late_col, .tx_max_col, .tx_exc_defer, .tx_defer, .tx_crc_bad, .tx_col_count,
        .receive_enable_bit, .rx_pkt_stored, .receive_active_in, .clocks_ready_in,
        .phy_duplex_in, .phy_link_in, .pause_send, .pause_zero, .pause_done,
        .backpressure, .int_n);
    ecsr_engine_model eng (.hclk, .hresetn, .lat, .cipher_go, .dma_go, .tx_go,
        .pause_send, .cipher_done, .dma_done, .tx_done, .pause_done);
    task automatic print_verdict;
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        bus(1'h0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic launch(input logic [31:0] v, input logic [31:0] sb);
        wr(12'h000, v);
        rc(12'h000, 32'hFFFF, v, "busy");
        repeat (40) @(posedge hclk);
        rc(12'h000, 32'hFFFF, v & ~sb, "done");
    endtask
    task automatic t_status;
        rc(12'h008, 32'h1000, 32'h0, "clk_rdy");
        clocks_ready_in <= 1'h1;
        repeat (4) @(posedge hclk);
        rc(12'h008, 32'h1000, 32'h1000, "clk_rdy");
        rc(12'h000, 32'hFFFFFFFF, 32'h0, "ctrl_rst");
        rc(12'h004, 32'hFFFFFFFF, 32'h0, "txstat_rst");
        wr(12'h020, 32'hFFFF);
        rc(12'h020, 32'hFFFFFFFF, 32'h0, "unmapped");
    endtask
    task automatic t_rx;
        wr(12'h000, 32'h1);
        @(negedge hclk) chk("rx_en", 32'h1, {31'h0, receive_enable_bit});
        receive_active_in <= 1'h1;
        phy_link_in <= 1'h1;
        phy_duplex_in <= 1'h1;
        repeat (4) @(posedge hclk);
        rc(12'h008, 32'h2500, 32'h2500, "rx_active");
        receive_active_in <= 1'h0;
        wr(12'h000, 32'h0);
        @(negedge hclk) chk("rx_en", 32'h0, {31'h0, receive_enable_bit});
    endtask
    task automatic t_cipher;
        for (int op = 0; op < 3; op++) begin
            wr(12'h000, 32'h800 | (op << 9));
            @(negedge hclk) chk("op", op, {30'h0, cipher_operation_select});
            launch(32'h800 | (op << 9), 32'h800);
        end
    endtask
    task automatic t_dma;
        wr(12'h00C, 32'h1234);
        dma_checksum_in <= 16'hBEEF;
        launch(32'h38, 32'h20);
        rc(12'h00C, 32'hFFFF, 32'hBEEF, "cksum");
        @(negedge hclk) chk("seed", 32'h4110, {16'h0, dma_seed});
        chk("copy", 32'h1, {31'h0, dma_copy_control});
        dma_checksum_in <= 16'h5555;
        launch(32'h24, 32'h20);
        rc(12'h00C, 32'hFFFF, 32'hBEEF, "cksum");
        chk("copy", 32'h0, {31'h0, dma_copy_control});
        chk("seed", 32'h0, {16'h0, dma_seed});
        chk("nocs", 32'h1, {31'h0, dma_no_checksum});
    endtask
    task automatic t_pkt;
        repeat (3) begin
            @(posedge hclk) rx_pkt_stored <= 1'h1;
            @(posedge hclk) rx_pkt_stored <= 1'h0;
        end
        rc(12'h008, 32'hFF, 32'h3, "received_packet_count");
        wr(12'h000, 32'h100);
        wr(12'h000, 32'h100);
        rc(12'h000, 32'h100, 32'h0, "dec_bit");
        rc(12'h008, 32'hFF, 32'h1, "received_packet_count");
    endtask
    task automatic t_int;
        wr(12'h014, 32'h1);
        wr(12'h018, 32'h1);
        rc(12'h008, 32'h8000, 32'h8000, "int");
        chk("int_n", 32'h1, {31'h0, int_n});
        wr(12'h018, 32'h8001);
        @(negedge hclk) chk("int_n", 32'h0, {31'h0, int_n});
        wr(12'h014, 32'h0);
        rc(12'h008, 32'h8000, 32'h0, "int");
        chk("int_n", 32'h1, {31'h0, int_n});
    endtask
    task automatic t_tx;
        {tx_late_col, tx_exc_defer, tx_crc_bad, tx_col_count} <= 7'h7A;
        launch(32'h2, 32'h2);
        rc(12'h004, 32'h79F, 32'h51A, "txstat");
        {tx_late_col, tx_max_col, tx_exc_defer, tx_defer} <= 4'h5;
        launch(32'h2, 32'h2);
        rc(12'h004, 32'h79F, 32'h29A, "txstat");
        rc(12'h008, 32'h4000, 32'h4000, "fc_idle");
        wr(12'h010, 32'h1);
        launch(32'h2, 32'h2);
        rc(12'h004, 32'h79F, 32'h10, "txstat");
    endtask
    task automatic t_flow;
        int n;
        logic prev;
        n = 0;
        prev = 1'h0;
        lat <= 8'h03;
        for (int k = 0; k < 2; k++) begin
            wr(12'h000, k ? 32'hC0 : 32'h40);
            @(negedge hclk);
            @(negedge hclk) chk("pause", {30'h0, k[0], 1'h1}, {pause_zero, pause_send});
            rc(12'h008, 32'h4000, 32'h0, "fc_idle");
            repeat (20) @(posedge hclk);
            rc(12'h000, 32'hC0, 32'h0, "fc_clr");
            rc(12'h008, 32'h4000, 32'h4000, "fc_idle");
        end
        wr(12'h000, 32'h80);
        repeat (100) begin
            @(negedge hclk);
            if (pause_send && !prev) n++;
            prev = pause_send;
        end
        chk("periodic", 32'h1, {31'h0, n >= 2});
        rc(12'h000, 32'hC0, 32'h80, "fc_hold");
        while (pause_send !== 1'h1) @(posedge hclk);
        while (pause_send !== 1'h0) @(posedge hclk);
        wr(12'h000, 32'hC0);
        @(negedge hclk);
        @(negedge hclk) chk("pause_end", 32'h3, {pause_zero, pause_send});
        repeat (20) @(posedge hclk);
        rc(12'h000, 32'hC0, 32'h0, "fc_end");
    endtask
    task automatic t_half;
        hresetn <= 1'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        chk("bp", 32'h0, {31'h0, backpressure});
        wr(12'h000, 32'h80);
        @(negedge hclk);
        @(negedge hclk) chk("bp", 32'h1, {pause_send, backpressure});
        rc(12'h008, 32'h4000, 32'h4000, "fc_idle");
        wr(12'h000, 32'h0);
        @(negedge hclk);
        @(negedge hclk) chk("bp_off", 32'h0, {pause_send, backpressure});
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        t_status();
        t_rx();
        t_cipher();
        t_dma();
        t_pkt();
        t_int();
        t_tx();
        t_flow();
        t_half();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        print_verdict();
    end
endmodule // tb_top
bind ecsr_regs ecsr_regs_chk #(.PAUSE_PERIOD(PAUSE_PERIOD)) chk_i (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .cipher_go,
    .cipher_done, .dma_go, .dma_done, .tx_go, .tx_done, .dma_seed_en, .dma_seed,
    .pause_send, .backpressure);
